// ===== rtl/ugp_gpio_top.sv
/*
 Upper GPIO ports 4 to 7: paged byte and bit access to data latches,
 output-type selection, pin reads and memory-interface strobe override.
 Assumes a paged register bus on CORE_CLK and pads resolved from PIN_OUT/PIN_OE.
*/
// What this block does
// - Port latches byte- and bit-accessible
// - Normal reads return sensed pin levels
// - Read-modify-write reads return latch contents
// - Push-pull: zero drives low, one high
// - Open-drain: zero drives low, one releases
// - Per-pin mode bit: set push-pull, clear open-drain
// - Latches and inputs usable without pins
// - Memory interface strobes drive port 4 top
`timescale 1ns/1ps
`include "ugp_regs.svh"

module ugp_gpio_top
    import ugp_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  SFR_PAGE,
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    input  wire logic        SFR_RMW,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    output logic             SFR_HIT,
    input  wire logic [7:0]  BIT_ADDR,
    input  wire logic        BIT_WR,
    input  wire logic        BIT_RD,
    input  wire logic        BIT_WDATA,
    output logic             BIT_RDATA,
    output logic             BIT_HIT,
    input  wire logic        EMIF_EN,
    input  wire logic        EMIF_WR_N,
    input  wire logic        EMIF_RD_N,
    input  wire logic        EMIF_ALE,
    input  wire logic [31:0] PIN_IN,
    output logic      [31:0] PIN_OUT,
    output logic      [31:0] PIN_OE
);
    ugp_bank_t   port_latch;
    ugp_bank_t   port_output_type_select;
    ugp_bank_t   next_port_latch;
    ugp_bank_t   next_port_output_type_select;
    logic [31:0] pin_level;
    logic [7:0]  next_sfr_rdata;
    logic        next_sfr_hit;
    logic        next_bit_rdata;
    logic        next_bit_hit;
    logic [31:0] next_pin_out;
    logic [31:0] next_pin_oe;
    ugp_hit_t    byte_dec;
    ugp_hit_t    bit_dec;
    ugp_hit_t    mode_dec;
    logic        page_ok;

    // Latch decode; bit form ignores the low three address bits
    function automatic ugp_hit_t latch_decode(input ugp_byte_t a, input logic bit_form);
        ugp_byte_t m;
        m = bit_form ? {a[7:`UGP_ROW_LSB], 3'h0} : a;
        if (m == `UGP_P4_ADDR) begin
            latch_decode = 3'h4;
        end else if (m == `UGP_P5_ADDR) begin
            latch_decode = 3'h5;
        end else if (m == `UGP_P6_ADDR) begin
            latch_decode = 3'h6;
        end else if (m == `UGP_P7_ADDR) begin
            latch_decode = 3'h7;
        end else begin
            latch_decode = 3'h0;
        end
    endfunction

    // Mode register decode; byte access only
    function automatic ugp_hit_t mode_decode(input ugp_byte_t a);
        if (a == `UGP_M4_ADDR) begin
            mode_decode = 3'h4;
        end else if (a == `UGP_M5_ADDR) begin
            mode_decode = 3'h5;
        end else if (a == `UGP_M6_ADDR) begin
            mode_decode = 3'h6;
        end else if (a == `UGP_M7_ADDR) begin
            mode_decode = 3'h7;
        end else begin
            mode_decode = 3'h0;
        end
    endfunction

    // Pin levels for reads, synchronised whether or not pins exist
    ugp_sync #(
        .WIDTH (32)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (RST),
        .din  (PIN_IN),
        .dout (pin_level)
    );

    always_comb begin
        next_port_latch              = port_latch;
        next_port_output_type_select = port_output_type_select;
        next_sfr_rdata               = 8'h00;
        next_sfr_hit                 = 1'b0;
        next_bit_rdata               = 1'b0;
        next_bit_hit                 = 1'b0;

        // Address decode and page gate
        byte_dec                     = latch_decode(SFR_ADDR, 1'b0);
        bit_dec                      = latch_decode(BIT_ADDR, 1'b1);
        mode_dec                     = mode_decode(SFR_ADDR);
        page_ok                      = (SFR_PAGE == `UGP_PAGE_F);

        // Byte writes
        if (page_ok && SFR_WR) begin
            if (byte_dec[2]) begin
                next_port_latch[byte_dec[1:0]] = SFR_WDATA;
            end else if (mode_dec[2]) begin
                next_port_output_type_select[mode_dec[1:0]] = SFR_WDATA;
            end
        end

        // Bit writes, applied after any byte write
        if (page_ok && BIT_WR && bit_dec[2]) begin
            next_port_latch[bit_dec[1:0]][BIT_ADDR[`UGP_BIT_MSB:0]] = BIT_WDATA;
        end

        // Byte reads
        if (page_ok && SFR_RD) begin
            if (byte_dec[2]) begin
                next_sfr_hit = 1'b1;
                if (SFR_RMW) begin
                    next_sfr_rdata = port_latch[byte_dec[1:0]];
                end else begin
                    next_sfr_rdata = pin_level[byte_dec[1:0]*`UGP_PORT_W +: `UGP_PORT_W];
                end
            end else if (mode_dec[2]) begin
                next_sfr_hit   = 1'b1;
                next_sfr_rdata = port_output_type_select[mode_dec[1:0]];
            end
        end

        // Bit reads
        if (page_ok && BIT_RD && bit_dec[2]) begin
            next_bit_hit = 1'b1;
            if (SFR_RMW) begin
                next_bit_rdata = port_latch[bit_dec[1:0]][BIT_ADDR[`UGP_BIT_MSB:0]];
            end else begin
                next_bit_rdata = pin_level[{bit_dec[1:0], BIT_ADDR[`UGP_BIT_MSB:0]}];
            end
        end
    end

    // Pin drive
    always_comb begin
        logic val;
        logic pp;
        val          = 1'b0;
        pp           = 1'b0;
        next_pin_out = 32'h0000_0000;
        next_pin_oe  = 32'h0000_0000;

        for (int p = 0; p < `UGP_NPORTS; p++) begin
            for (int b = 0; b < `UGP_PORT_W; b++) begin
                val = port_latch[p][b];
                pp  = port_output_type_select[p][b];
                // Memory interface strobes own port 4 top
                if (p == 0 && EMIF_EN) begin
                    if (b == `UGP_EMIF_WR_BIT) begin
                        val = EMIF_WR_N;
                        pp  = 1'b1;
                    end else if (b == `UGP_EMIF_RD_BIT) begin
                        val = EMIF_RD_N;
                        pp  = 1'b1;
                    end else if (b == `UGP_EMIF_AL_BIT) begin
                        val = EMIF_ALE;
                        pp  = 1'b1;
                    end
                end

                // Open-drain releases instead of driving high
                if (pp) begin
                    next_pin_out[p*`UGP_PORT_W+b] = val;
                    next_pin_oe[p*`UGP_PORT_W+b]  = 1'b1;
                end else begin
                    next_pin_out[p*`UGP_PORT_W+b] = 1'b0;
                    next_pin_oe[p*`UGP_PORT_W+b]  = ~val;
                end
            end
        end
    end

    // Register stage; every output from a flop
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            port_latch              <= {`UGP_NPORTS{`UGP_LATCH_RST}};
            port_output_type_select <= {`UGP_NPORTS{`UGP_MODE_RST}};
            SFR_RDATA               <= 8'h00;
            SFR_HIT                 <= 1'b0;
            BIT_RDATA               <= 1'b0;
            BIT_HIT                 <= 1'b0;
            PIN_OUT                 <= 32'h0000_0000;
            PIN_OE                  <= 32'h0000_0000;
        end else begin
            port_latch              <= next_port_latch;
            port_output_type_select <= next_port_output_type_select;
            SFR_RDATA               <= next_sfr_rdata;
            SFR_HIT                 <= next_sfr_hit;
            BIT_RDATA               <= next_bit_rdata;
            BIT_HIT                 <= next_bit_hit;
            PIN_OUT                 <= next_pin_out;
            PIN_OE                  <= next_pin_oe;
        end
    end
endmodule

// ===== rtl/ugp_pkg.sv
/*
 Shared types of the upper GPIO ports.
 Assumes nothing of its surroundings.
*/
package ugp_pkg;
    typedef logic [7:0]      ugp_byte_t;
    typedef logic [1:0]      ugp_idx_t;
    typedef logic [3:0][7:0] ugp_bank_t;
    typedef logic [2:0]      ugp_hit_t;
endpackage

// ===== rtl/ugp_regs.svh
/*
 Register addresses, reset values and pin positions of the upper GPIO ports.
 Assumes inclusion by bare name from the design files.
*/
`ifndef UGP_REGS_SVH
`define UGP_REGS_SVH

`define UGP_PAGE_F      8'h0f
`define UGP_P4_ADDR     8'hc8
`define UGP_P5_ADDR     8'hd8
`define UGP_P6_ADDR     8'he8
`define UGP_P7_ADDR     8'hf8
`define UGP_M4_ADDR     8'h9c
`define UGP_M5_ADDR     8'h9d
`define UGP_M6_ADDR     8'h9e
`define UGP_M7_ADDR     8'h9f
`define UGP_LATCH_RST   8'hff
`define UGP_MODE_RST    8'h00
`define UGP_PIN_RST     1'b1
`define UGP_BIT_MSB     2
`define UGP_ROW_LSB     3
`define UGP_EMIF_WR_BIT 7
`define UGP_EMIF_RD_BIT 6
`define UGP_EMIF_AL_BIT 5
`define UGP_NPORTS      4
`define UGP_PORT_W      8

`endif

// ===== rtl/ugp_sync.sv
/*
 Three-stage pin synchroniser; output follows once stages two and three agree.
 Assumes asynchronous inputs and one clock with synchronous reset.
*/
`timescale 1ns/1ps
`include "ugp_regs.svh"

module ugp_sync
    import ugp_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_dout = dout;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_dout[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= {WIDTH{`UGP_PIN_RST}};
            stage2 <= {WIDTH{`UGP_PIN_RST}};
            stage3 <= {WIDTH{`UGP_PIN_RST}};
            dout   <= {WIDTH{`UGP_PIN_RST}};
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout   <= next_dout;
        end
    end
endmodule

// ===== verification/tb_top.sv
/*
 Self-checking bench of the upper GPIO ports.
 Assumes the design, its checker and the pad model compiled before.
*/
`timescale 1ns/1ps
module tb_top;
    import ugp_pkg::*;
    logic        CORE_CLK = 0, RST = 1, SFR_WR = 0, SFR_RD = 0, SFR_RMW = 0, BIT_WR = 0, BIT_RD = 0;
    logic        BIT_WDATA = 0, EMIF_EN = 0, EMIF_WR_N = 1, EMIF_RD_N = 1, EMIF_ALE = 0;
    logic        SFR_HIT, BIT_RDATA, BIT_HIT, h, b;
    ugp_byte_t   SFR_PAGE = 8'h0f, SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, BIT_ADDR = 8'h00, SFR_RDATA, d, e;
    logic [31:0] PIN_IN, PIN_OUT, PIN_OE, pull_low = '0;
    ugp_bank_t   lat, mode;
    ugp_idx_t    p;
    logic [2:0]  k;
    int          n_mismatch = 0, n_checks = 0;
    always #2.5 CORE_CLK = ~CORE_CLK;
    ugp_gpio_top i_ugp_gpio_top(.CORE_CLK, .RST, .SFR_PAGE, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_RMW,
        .SFR_WDATA, .SFR_RDATA, .SFR_HIT, .BIT_ADDR, .BIT_WR, .BIT_RD, .BIT_WDATA, .BIT_RDATA, .BIT_HIT,
        .EMIF_EN, .EMIF_WR_N, .EMIF_RD_N, .EMIF_ALE, .PIN_IN, .PIN_OUT, .PIN_OE);
    ugp_pads i_ugp_pads(.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_low, .pin_in(PIN_IN));
    function automatic ugp_byte_t pad(ugp_idx_t q);
        return (mode[q] & lat[q]) | (~mode[q] & lat[q] & ~pull_low[8*q +: 8]);
    endfunction
    task automatic chk8(string n, ugp_byte_t exp, ugp_byte_t got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Optional write, then a read of the same place in the next cycle
    task automatic acc(logic bm, logic w, logic r, ugp_byte_t a, ugp_byte_t wd);
        @(posedge CORE_CLK);
        SFR_ADDR <= a;
        BIT_ADDR <= a;
        SFR_WDATA <= wd;
        BIT_WDATA <= wd[0];
        if (w) begin
            SFR_WR <= !bm;
            BIT_WR <= bm;
            @(posedge CORE_CLK);
            SFR_WR <= 0;
            BIT_WR <= 0;
        end
        SFR_RMW <= r;
        SFR_RD <= !bm;
        BIT_RD <= bm;
        @(posedge CORE_CLK);
        SFR_RD <= 0;
        BIT_RD <= 0;
        #1;
        d = SFR_RDATA;
        h = bm ? BIT_HIT : SFR_HIT;
        b = BIT_RDATA;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge CORE_CLK);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hf23a));
        repeat (20) @(posedge CORE_CLK);
        RST <= 0;
        lat = {4{8'hff}};
        mode = '0;
        repeat (8) @(posedge CORE_CLK);
        #1;
        chk8("oe_reset", 8'h00, PIN_OE[7:0]);
        chk8("out_reset", 8'h00, PIN_OUT[7:0]);
        acc(0, 0, 1, 8'hc8, 8'h00);
        chk8("latch_reset", 8'hff, d);
        for (int i = 0; i < 24; i++) begin
            p = i[1:0];
            pull_low[8*p +: 8] <= 8'($urandom);
            mode[p] = (i < 4) ? 8'hff : (i < 8) ? 8'h00 : 8'($urandom);
            lat[p] = (i < 4) ? 8'h00 : 8'($urandom);
            acc(0, 1, 0, {6'h27, p}, mode[p]);
            chk8("mode", mode[p], d);
            acc(0, 1, 1, {2'b11, p, 4'h8}, lat[p]);
            chk8("latch_rmw", lat[p], d);
            chk8("hit", 8'h01, {7'h0, h});
            repeat (6) @(posedge CORE_CLK);
            acc(0, 0, 0, {2'b11, p, 4'h8}, 8'h00);
            chk8("pin_read", pad(p), d);
            chk8("pin_oe", mode[p] | ~lat[p], PIN_OE[8*p +: 8]);
            chk8("pin_out", mode[p] & lat[p], PIN_OUT[8*p +: 8]);
        end
        for (int i = 0; i < 16; i++) begin
            p = 2'($urandom);
            k = 3'($urandom);
            e = 8'($urandom);
            acc(1, 1, 1, {2'b11, p, 1'b1, k}, e);
            lat[p][k] = e[0];
            chk8("bit_rmw", {7'h0, e[0]}, {7'h0, b});
            chk8("bit_hit", 8'h01, {7'h0, h});
            acc(0, 0, 1, {2'b11, p, 4'h8}, 8'h00);
            chk8("byte_after_bit", lat[p], d);
            repeat (6) @(posedge CORE_CLK);
            acc(1, 0, 0, {2'b11, p, 1'b1, k}, 8'h00);
            e = pad(p);
            chk8("bit_pin", {7'h0, e[k]}, {7'h0, b});
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge CORE_CLK);
            EMIF_EN <= 1;
            {EMIF_WR_N, EMIF_RD_N, EMIF_ALE} <= 3'($urandom);
        end
        repeat (6) @(posedge CORE_CLK);
        acc(0, 0, 0, 8'hc8, 8'h00);
        e = pad(0);
        e[7:5] = {EMIF_WR_N, EMIF_RD_N, EMIF_ALE};
        chk8("strobe_pins", e, d);
        SFR_PAGE <= 8'h0e;
        acc(0, 1, 1, 8'hc8, 8'h5a);
        chk8("page_miss", 8'h00, d);
        chk8("page_miss_hit", 8'h00, {7'h0, h});
        SFR_PAGE <= 8'h0f;
        acc(0, 0, 1, 8'hc8, 8'h00);
        chk8("latch_kept", lat[0], d);
        acc(0, 0, 0, 8'h9b, 8'h00);
        chk8("unmapped", 8'h00, {d[7:1], h});
        print_verdict();
    end
endmodule

// ===== verification/ugp_chk_asserts.sv
/*
 Port-level checker of the upper GPIO ports.
 Assumes it is bound to ugp_gpio_top and sees only its ports.
*/
`timescale 1ns/1ps
module ugp_chk(
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic [7:0]  SFR_PAGE,
    input wire logic [7:0]  SFR_ADDR,
    input wire logic        SFR_WR,
    input wire logic        SFR_RD,
    input wire logic        SFR_RMW,
    input wire logic [7:0]  SFR_WDATA,
    input wire logic [7:0]  SFR_RDATA,
    input wire logic        SFR_HIT,
    input wire logic [7:0]  BIT_ADDR,
    input wire logic        BIT_WR,
    input wire logic        BIT_RD,
    input wire logic        BIT_WDATA,
    input wire logic        BIT_RDATA,
    input wire logic        BIT_HIT,
    input wire logic        EMIF_EN,
    input wire logic        EMIF_WR_N,
    input wire logic        EMIF_RD_N,
    input wire logic        EMIF_ALE,
    input wire logic [31:0] PIN_IN,
    input wire logic [31:0] PIN_OUT,
    input wire logic [31:0] PIN_OE
);
    wire logic pg = (SFR_PAGE == 8'h0f);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    read_hit_a: assert property (SFR_RD && pg && SFR_ADDR == 8'hc8 |=> SFR_HIT)
        else $error("latch read not answered");
    page_miss_a: assert property (SFR_RD && !pg |=> !SFR_HIT && SFR_RDATA == 8'h00)
        else $error("off-page read answered");
    rmw_latch_a: assert property (SFR_WR && pg && SFR_ADDR == 8'hc8 && !BIT_WR ##1
        SFR_RD && SFR_RMW && pg && SFR_ADDR == 8'hc8 |=> SFR_RDATA == $past(SFR_WDATA, 2))
        else $error("rmw read not latch");
    pin_read_a: assert property ($stable(PIN_IN[15:8])[*6] ##0
        SFR_RD && !SFR_RMW && pg && SFR_ADDR == 8'hd8 |=> SFR_RDATA == $past(PIN_IN[15:8]))
        else $error("pin read wrong");
    push_pull_a: assert property (SFR_WR && pg && SFR_ADDR == 8'h9d && SFR_WDATA == 8'hff ##1
        (!SFR_WR && !BIT_WR)[*2] ##1 SFR_WR && pg && SFR_ADDR == 8'hd8 && !BIT_WR
        |=> ##1 PIN_OE[15:8] == 8'hff && PIN_OUT[15:8] == $past(SFR_WDATA, 2))
        else $error("push-pull drive wrong");
    open_drain_a: assert property (SFR_WR && pg && SFR_ADDR == 8'h9e && SFR_WDATA == 8'h00 ##1
        (!SFR_WR && !BIT_WR)[*2] ##1 SFR_WR && pg && SFR_ADDR == 8'he8 && !BIT_WR
        |=> ##1 PIN_OE[23:16] == ~$past(SFR_WDATA, 2) && PIN_OUT[23:16] == 8'h00)
        else $error("open-drain drive wrong");
    emif_own_a: assert property (EMIF_EN |=> PIN_OE[7:5] == 3'b111
        && PIN_OUT[7:5] == $past({EMIF_WR_N, EMIF_RD_N, EMIF_ALE}))
        else $error("strobe override wrong");
    bit_rmw_a: assert property (BIT_WR && pg && BIT_ADDR[7:3] == 5'h19 ##1
        BIT_RD && SFR_RMW && pg && BIT_ADDR == $past(BIT_ADDR) |=> BIT_RDATA == $past(BIT_WDATA, 2))
        else $error("bit write lost");
    bit_hit_a: assert property (BIT_RD && pg && BIT_ADDR[7:3] == 5'h19 |=> BIT_HIT)
        else $error("bit read not answered");
endmodule
bind ugp_gpio_top ugp_chk i_ugp_chk(.CORE_CLK, .RST, .SFR_PAGE, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_RMW,
    .SFR_WDATA, .SFR_RDATA, .SFR_HIT, .BIT_ADDR, .BIT_WR, .BIT_RD, .BIT_WDATA, .BIT_RDATA, .BIT_HIT, .EMIF_EN,
    .EMIF_WR_N, .EMIF_RD_N, .EMIF_ALE, .PIN_IN, .PIN_OUT, .PIN_OE);

// ===== verification/ugp_pads.sv
/*
 Board model of the 32 pads: weak pull-ups and devices pulling low.
 Assumes pad enables from the design and a pull-low mask from the bench.
*/
`timescale 1ns/1ps
module ugp_pads(
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pull_low,
    output logic     [31:0] pin_in
);
    // Driven pads follow the driver, released ones the board
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~pull_low);
endmodule
